/* hw/isafid_cipher_latch.sv */
`timescale 1ns/100ps
// catches the implemented flag once, at the first cycle after reset release
module isafid_cipher_latch (
	input  wire logic CLOCK,
	input  wire logic SRST,
	input  wire logic build_param,
	input  wire logic disable_in,
	output logic      present
);
	typedef struct packed {
		logic armed;
		logic present;
	} isafid_latch_st_t;

	isafid_latch_st_t st_ff;
	isafid_latch_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (SRST) begin
			nxt_st.armed   = 1'b1;
			nxt_st.present = 1'b0;
		end else if (st_ff.armed) begin
			// disable is sampled while reset is being released
			nxt_st.armed   = 1'b0;
			nxt_st.present = build_param & ~disable_in;
		end
	end

	always_ff @(posedge CLOCK) begin
		st_ff <= nxt_st;
	end

	assign present = st_ff.present;
endmodule : isafid_cipher_latch

/* hw/isafid_field.sv */
`timescale 1ns/100ps
// one cipher_ext_build_param-dependent nibble: full value when enabled, zero otherwise
module isafid_field #(
	parameter logic [3:0] ENABLED_VAL = 4'h0
) (
	input  wire logic       enable,
	output logic [3:0]      value
);
	assign value = enable ? ENABLED_VAL : isafid_pkg::VAL_ABSENT;
endmodule : isafid_field

/* hw/isafid_pkg.sv */
package isafid_pkg;

	localparam int FIELD_W = 4;
	localparam int REG_W   = 64;

	// field positions (low bit)
	localparam int POS_RANDOM      = 60;
	localparam int POS_TRANSLATION = 56;
	localparam int POS_FLAG_MANIP  = 52;
	localparam int POS_HALF_FUSED  = 48;
	localparam int POS_DOT_PRODUCT = 44;
	localparam int POS_NAT_CIPHER  = 40;
	localparam int POS_NAT_HASH    = 36;
	localparam int POS_HASH_GEN3   = 32;
	localparam int POS_ROUND_MAC   = 28;
	localparam int POS_TRANS_MEM   = 24;
	localparam int POS_ATOMIC      = 20;
	localparam int POS_CHECKSUM    = 16;
	localparam int POS_HASH_GEN2   = 12;
	localparam int POS_HASH_GEN1   = 8;
	localparam int POS_BLOCK_CIPH  = 4;

	// field values
	localparam logic [3:0] VAL_RANDOM      = 4'h0;
	localparam logic [3:0] VAL_TRANSLATION = 4'h2;
	localparam logic [3:0] VAL_FLAG_MANIP  = 4'h2;
	localparam logic [3:0] VAL_HALF_FUSED  = 4'h1;
	localparam logic [3:0] VAL_DOT_PRODUCT = 4'h1;
	localparam logic [3:0] VAL_NAT_CIPHER  = 4'h1;
	localparam logic [3:0] VAL_NAT_HASH    = 4'h1;
	localparam logic [3:0] VAL_HASH_GEN3   = 4'h1;
	localparam logic [3:0] VAL_ROUND_MAC   = 4'h1;
	localparam logic [3:0] VAL_TRANS_MEM   = 4'h0;
	localparam logic [3:0] VAL_ATOMIC      = 4'h2;
	localparam logic [3:0] VAL_CHECKSUM    = 4'h1;
	localparam logic [3:0] VAL_HASH_GEN2   = 4'h2;
	localparam logic [3:0] VAL_HASH_GEN1   = 4'h1;
	localparam logic [3:0] VAL_BLOCK_CIPH  = 4'h2;
	localparam logic [3:0] VAL_ABSENT      = 4'h0;

	// register select encoding
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [2:0] ENC_OP1 = 3'h0;
	localparam logic [3:0] ENC_CRN = 4'h0;
	localparam logic [3:0] ENC_CRM = 4'h6;
	localparam logic [2:0] ENC_OP2 = 3'h0;

	localparam logic [5:0] TRAP_CLASS = 6'h18;

	localparam logic [1:0] LVL_0 = 2'h0;
	localparam logic [1:0] LVL_1 = 2'h1;
	localparam logic [1:0] LVL_2 = 2'h2;

	typedef struct packed {
		logic [1:0] op0;
		logic [2:0] op1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] op2;
	} isafid_enc_t;

	typedef struct packed {
		logic       valid;
		isafid_enc_t enc;
		logic [1:0] current_exception_level;
		logic       lvl2_enabled;
		logic       hyp_trap_general_ctrl;
		logic       hyp_trap_id_group3_ctrl;
	} isafid_req_t;

	typedef struct packed {
		logic       done;
		logic       hit;
		logic       trap;
		logic [1:0] trap_level;
		logic [5:0] trap_class;
		logic [63:0] data;
	} isafid_rsp_t;

endpackage : isafid_pkg

/* hw/isafid_top.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// R01 - 64-bit read-only register reports implemented instruction groups
// R02 - bits 63:60 random number field read zero
// R03 - bits 59:56 translation maintenance field read 2
// R04 - bits 55:52 flag manipulation field read 2
// R05 - bits 51:48 half fused multiply long field read 1
// R06 - bits 47:44 dot product field read 1
// R07 - bits 43:40 national cipher read 1 when cipher_ext_build_param enabled, else 0
// R08 - bits 39:36 national hash read 1 when cipher_ext_build_param enabled, else 0
// R09 - bits 35:32 third generation hash read 1 when enabled, else 0
// R10 - bits 31:28 rounding multiply accumulate field read 1
// R11 - bits 27:24 transactional memory field read 0
// R12 - at levels 1 and 2 transactional field reads zero, writes ignored
// R13 - bits 23:20 atomic field read 2
// R14 - bits 19:16 checksum field read 1
// R15 - bits 15:12 second generation hash read 2 when enabled, else 0
// R16 - bits 11:8 first generation hash read 1 when enabled, else 0
// R17 - bits 7:4 block cipher read 2 when enabled, else 0; 3:0 zero
// R18 - cipher_ext_build_param present only if build parameter true and disable low at reset
// R19 - selected by encoding op0 3, op1 0, CRn 0, CRm 6, op2 0
// R20 - level 0 read traps class 0x18 to 2 if general trap, else 1
// R21 - level 1 read traps to 2 when group3 trap set and level 2 on
// R22 - level 2 or 3 read always returns full value
// R23 - system asserts disable for the whole cluster to turn cipher_ext_build_param off
// R24 - cipher_ext_build_param fields captured at reset and held until next reset
module isafid_top #(
	parameter bit CIPHER_EXT_BUILD_PARAM = 1'b1
) (
	input  wire logic                 CLOCK,
	input  wire logic                 SRST,
	input  wire logic                 CIPHER_EXT_DISABLE_IN,
	input  wire isafid_pkg::isafid_req_t REQ,
	output isafid_pkg::isafid_rsp_t   RSP
);
	typedef struct packed {
		isafid_pkg::isafid_rsp_t rsp;
	} isafid_st_t;

	isafid_st_t st_ff;
	isafid_st_t nxt_st;

	logic        cipher_on;
	logic [3:0]  nat_cipher_v;
	logic [3:0]  nat_hash_v;
	logic [3:0]  hash3_v;
	logic [3:0]  hash2_v;
	logic [3:0]  hash1_v;
	logic [3:0]  block_v;
	logic [63:0] reg_value;
	logic        sel;

	//////////////////////////////////////////////////////////////////////////
	// cipher_ext_build_param presence, frozen after reset so a late disable edge has no effect
	isafid_cipher_latch u_latch (
		.CLOCK       (CLOCK),
		.SRST        (SRST),
		.build_param (CIPHER_EXT_BUILD_PARAM),
		.disable_in  (CIPHER_EXT_DISABLE_IN), // R23
		.present     (cipher_on)              // R18 R24
	);

	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_NAT_CIPHER)) u_f_ncip (
		.enable (cipher_on),
		.value  (nat_cipher_v) // R07
	);
	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_NAT_HASH)) u_f_nhash (
		.enable (cipher_on),
		.value  (nat_hash_v) // R08
	);
	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_HASH_GEN3)) u_f_h3 (
		.enable (cipher_on),
		.value  (hash3_v) // R09
	);
	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_HASH_GEN2)) u_f_h2 (
		.enable (cipher_on),
		.value  (hash2_v) // R15
	);
	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_HASH_GEN1)) u_f_h1 (
		.enable (cipher_on),
		.value  (hash1_v) // R16
	);
	isafid_field #(.ENABLED_VAL(isafid_pkg::VAL_BLOCK_CIPH)) u_f_blk (
		.enable (cipher_on),
		.value  (block_v) // R17
	);

	//////////////////////////////////////////////////////////////////////////
	// register image; no write path exists, so the register is read-only
	always_comb begin
		reg_value = '0; // R01 R17
		reg_value[isafid_pkg::POS_RANDOM +: 4]      = isafid_pkg::VAL_RANDOM;      // R02
		reg_value[isafid_pkg::POS_TRANSLATION +: 4] = isafid_pkg::VAL_TRANSLATION; // R03
		reg_value[isafid_pkg::POS_FLAG_MANIP +: 4]  = isafid_pkg::VAL_FLAG_MANIP;  // R04
		reg_value[isafid_pkg::POS_HALF_FUSED +: 4]  = isafid_pkg::VAL_HALF_FUSED;  // R05
		reg_value[isafid_pkg::POS_DOT_PRODUCT +: 4] = isafid_pkg::VAL_DOT_PRODUCT; // R06
		reg_value[isafid_pkg::POS_NAT_CIPHER +: 4]  = nat_cipher_v;                // R07
		reg_value[isafid_pkg::POS_NAT_HASH +: 4]    = nat_hash_v;                  // R08
		reg_value[isafid_pkg::POS_HASH_GEN3 +: 4]   = hash3_v;                     // R09
		reg_value[isafid_pkg::POS_ROUND_MAC +: 4]   = isafid_pkg::VAL_ROUND_MAC;   // R10
		reg_value[isafid_pkg::POS_TRANS_MEM +: 4]   = isafid_pkg::VAL_TRANS_MEM;   // R11
		reg_value[isafid_pkg::POS_ATOMIC +: 4]      = isafid_pkg::VAL_ATOMIC;      // R13
		reg_value[isafid_pkg::POS_CHECKSUM +: 4]    = isafid_pkg::VAL_CHECKSUM;    // R14
		reg_value[isafid_pkg::POS_HASH_GEN2 +: 4]   = hash2_v;                     // R15
		reg_value[isafid_pkg::POS_HASH_GEN1 +: 4]   = hash1_v;                     // R16
		reg_value[isafid_pkg::POS_BLOCK_CIPH +: 4]  = block_v;                     // R17
		// levels 1 and 2 see zero in this field anyway; kept explicit
		if (REQ.current_exception_level == isafid_pkg::LVL_1 ||
		    REQ.current_exception_level == isafid_pkg::LVL_2) begin
			reg_value[isafid_pkg::POS_TRANS_MEM +: 4] = 4'h0; // R12
		end
	end

	assign sel = REQ.enc.op0 == isafid_pkg::ENC_OP0 &&
	             REQ.enc.op1 == isafid_pkg::ENC_OP1 &&
	             REQ.enc.crn == isafid_pkg::ENC_CRN &&
	             REQ.enc.crm == isafid_pkg::ENC_CRM &&
	             REQ.enc.op2 == isafid_pkg::ENC_OP2; // R19

	//////////////////////////////////////////////////////////////////////////
	// access check, answer one cycle after the request
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rsp = '0;
		if (SRST) begin
			nxt_st.rsp = '0;
		end else if (REQ.valid) begin
			nxt_st.rsp.done = 1'b1;
			nxt_st.rsp.hit  = sel;
			if (sel) begin
				case (REQ.current_exception_level)
					isafid_pkg::LVL_0: begin
						nxt_st.rsp.trap       = 1'b1; // R20
						nxt_st.rsp.trap_class = isafid_pkg::TRAP_CLASS;
						nxt_st.rsp.trap_level =
							(REQ.lvl2_enabled && REQ.hyp_trap_general_ctrl) ?
							isafid_pkg::LVL_2 : isafid_pkg::LVL_1; // R20
					end
					isafid_pkg::LVL_1: begin
						if (REQ.lvl2_enabled && REQ.hyp_trap_id_group3_ctrl) begin
							nxt_st.rsp.trap       = 1'b1; // R21
							nxt_st.rsp.trap_class = isafid_pkg::TRAP_CLASS;
							nxt_st.rsp.trap_level = isafid_pkg::LVL_2;
						end else begin
							nxt_st.rsp.data = reg_value; // R21
						end
					end
					default: begin
						nxt_st.rsp.data = reg_value; // R22
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		st_ff <= nxt_st;
	end

	assign RSP = st_ff.rsp;
endmodule : isafid_top

/* sim/isafid_assertions.sv */
`timescale 1ns/100ps
module isafid_chk #(
	parameter bit CIPHER_EXT_BUILD_PARAM = 1'b1
) (
	input wire logic                    CLOCK,
	input wire logic                    SRST,
	input wire logic                    CIPHER_EXT_DISABLE_IN,
	input wire isafid_pkg::isafid_req_t REQ,
	input wire isafid_pkg::isafid_rsp_t RSP
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SRST);
	logic first_ff;
	logic on_ff;
	wire logic m  = REQ.valid && REQ.enc == 16'hc030;
	wire logic ok = RSP.done && RSP.hit && !RSP.trap;
	wire logic [1:0] lv = REQ.current_exception_level;
	// own copy of the at-reset sample, so a late toggle cannot leak in
	always_ff @(posedge CLOCK) begin
		first_ff <= SRST;
		if (first_ff && !SRST) on_ff <= CIPHER_EXT_BUILD_PARAM && !CIPHER_EXT_DISABLE_IN;
	end
	//////////////////////////////////////////////////////////////////////////////
	a_answer_next: assert property (REQ.valid |=> RSP.done && RSP.hit == $past(m))
		else $error("no answer one cycle after a read");
	a_idle_quiet: assert property (!REQ.valid |=> RSP == '0)
		else $error("response without a read");
	a_fixed_fields: assert property (ok |-> RSP.data[63:44] == 20'h02211
		&& RSP.data[31:16] == 16'h1021) else $error("fixed field wrong");
	a_cipher_group: assert property (ok |->
		{RSP.data[43:32], RSP.data[15:0]} inside {28'h0, 28'h1112120}) else $error("cipher_ext_build_param mix");
	a_cipher_state: assert property (ok |-> RSP.data[8] == on_ff)
		else $error("cipher_ext_build_param state differs from reset sample");
	a_lvl0_trap: assert property (m && lv == 2'h0 |=> RSP.trap && RSP.trap_class == 6'h18
		&& RSP.data == '0 && RSP.trap_level == ($past(REQ.lvl2_enabled
		&& REQ.hyp_trap_general_ctrl) ? 2'h2 : 2'h1)) else $error("level 0 trap wrong");
	a_lvl1_gate: assert property (m && lv == 2'h1 |=> RSP.trap ==
		$past(REQ.lvl2_enabled && REQ.hyp_trap_id_group3_ctrl)) else $error("level 1 gate");
	a_upper_free: assert property (m && lv[1] |=> ok)
		else $error("upper level read refused");
	a_miss_empty: assert property (REQ.valid && !m |=> !RSP.hit && !RSP.trap && RSP.data == '0)
		else $error("miss returned data");
	c_trap: cover property (m && lv == 2'h0);
	c_on: cover property (ok && on_ff);
	c_off: cover property (ok && !on_ff);
	c_miss: cover property (REQ.valid && !m);
endmodule : isafid_chk

bind isafid_top isafid_chk #(.CIPHER_EXT_BUILD_PARAM(CIPHER_EXT_BUILD_PARAM)) u_isafid_chk (
	.CLOCK(CLOCK), .SRST(SRST), .CIPHER_EXT_DISABLE_IN(CIPHER_EXT_DISABLE_IN),
	.REQ(REQ), .RSP(RSP));

/* sim/isafid_core.sv */
`timescale 1ns/100ps
// core read path: one register read per call, held for one edge
module isafid_core (
	input wire logic                CLOCK,
	output isafid_pkg::isafid_req_t REQ
);
	initial REQ = '0;
	task automatic read(input logic [15:0] e, input logic [1:0] l, input logic [2:0] c);
		@(negedge CLOCK);
		REQ <= {1'b1, e, l, c};
		@(negedge CLOCK);
		// idle fields flip so a stale value is never taken as live
		REQ <= {1'b0, ~e, ~l, ~c};
	endtask : read
endmodule : isafid_core

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	logic                    CLOCK = 1'b0;
	logic                    SRST = 1'b1;
	logic                    CIPHER_EXT_DISABLE_IN = 1'b0;
	isafid_pkg::isafid_req_t REQ;
	isafid_pkg::isafid_rsp_t RSP;
	isafid_pkg::isafid_rsp_t rsp_off;
	int                      miscompares = 0;
	int                      comparisons = 0;
	int                      cyc = 0;
	always #5 CLOCK = ~CLOCK;
	isafid_core u_core (.CLOCK(CLOCK), .REQ(REQ));
	isafid_top u_isafid_top (.CLOCK(CLOCK), .SRST(SRST),
		.CIPHER_EXT_DISABLE_IN(CIPHER_EXT_DISABLE_IN), .REQ(REQ), .RSP(RSP));
	// build without cipher_ext_build_param: the fields must stay absent whatever the disable pin does
	if (1'b1) begin : g_no_build
		isafid_top #(.CIPHER_EXT_BUILD_PARAM(1'b0)) u_isafid_top (.CLOCK(CLOCK), .SRST(SRST),
			.CIPHER_EXT_DISABLE_IN(CIPHER_EXT_DISABLE_IN), .REQ(REQ), .RSP(rsp_off));
	end
	//////////////////////////////////////////////////////////////////////////////
	function automatic isafid_pkg::isafid_rsp_t expect_rsp(logic [15:0] e, logic [1:0] l,
		logic [2:0] c, logic on);
		isafid_pkg::isafid_rsp_t r;
		r = '0;
		r.done = 1'b1;
		r.hit = (e == 16'hc030);
		r.trap = r.hit && (l == 2'h0 || (l == 2'h1 && c[2] && c[0]));
		if (r.trap) begin
			r.trap_class = 6'h18;
			r.trap_level = (l == 2'h1 || (c[2] && c[1])) ? 2'h2 : 2'h1;
		end else if (r.hit)
			r.data = on ? 64'h0221_1111_1021_2120 : 64'h0221_1000_1021_0000;
		return r;
	endfunction : expect_rsp
	task automatic do_read(logic [15:0] e, logic [1:0] l, logic [2:0] c, logic on);
		u_core.read(e, l, c);
		comparisons++;
		if (RSP !== expect_rsp(e, l, c, on)) begin
			miscompares++;
			$display("BAD rsp exp %h got %h", expect_rsp(e, l, c, on), RSP);
		end
		comparisons++;
		if (rsp_off !== expect_rsp(e, l, c, 1'b0)) begin
			miscompares++;
			$display("BAD rsp_off exp %h got %h", expect_rsp(e, l, c, 1'b0), rsp_off);
		end
	endtask : do_read
	task automatic run(input logic dis, input logic on);
		int          i;
		logic [31:0] rnd;
		logic [15:0] e;
		SRST = 1'b1;
		CIPHER_EXT_DISABLE_IN = dis;
		repeat (12) @(negedge CLOCK);
		SRST = 1'b0;
		repeat (2) @(negedge CLOCK);
		for (i = 0; i < 32; i++) begin
			do_read(16'hc030, i[4:3], i[2:0], on);
		end
		for (i = 0; i < 200; i++) begin
			rnd = $urandom;
			e = (rnd[1:0] == 2'h0) ? 16'hc030 ^ (16'h1 << rnd[11:8]) : 16'hc030;
			// toggling after reset must leave the fields alone
			CIPHER_EXT_DISABLE_IN = rnd[2];
			do_read(e, rnd[4:3], rnd[7:5], on);
		end
		$display("test done disable=%0b", dis);
	endtask : run
	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(31));
		run(1'b0, 1'b1);
		run(1'b1, 1'b0);
		run(1'b0, 1'b1);
		stop_test();
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			stop_test();
		end
	end
endmodule : tb_top
